// ### pec_crc8.sv
`timescale 1ns/1ps
`include "smb_params.svh"
// one byte of the packet check, msb first
module pec_crc8 (
  // running value and byte
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  // updated value
  output logic [7:0] crc_out
);
  logic [7:0] c;
  // shift loop unrolled by the tool, one xor tap set per bit
  always_comb
  begin
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `SMB_CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule

// ### reg_mem.sv
`timescale 1ns/1ps
// default page register storage, registered read
module reg_mem (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];
  // no reset: entries 30h..8Ch come from the boot copy
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### smb_master.sv
`timescale 1ns/1ps
// bus master model; scl stands high between frames
module smb_master (
  // timing reference
  input wire logic mclk,
  // wire
  input wire logic sda_w,
  output logic scl,
  output logic sda_d
);
  initial
  begin
    scl = 1'b1;
    sda_d = 1'b1;
  end
  // quarter bit; keeps each scl phase well over four link cycles
  task q();
    repeat (4) @(negedge mclk);
  endtask
  // sda falls while scl is high
  task start();
    sda_d = 1'b1;
    scl = 1'b1;
    q();
    sda_d = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  // sda rises while scl is high, then the wire is released
  task stop();
    sda_d = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_d = 1'b1;
    q();
  endtask
  // data changes only while scl is low; sampled mid high phase
  task bitx(input logic b, output logic s);
    sda_d = b;
    q();
    scl = 1'b1;
    q();
    s = sda_w;
    q();
    scl = 1'b0;
    q();
  endtask
  // eight bits msb first, then the ninth clock reads the ack
  task wbyte(input logic [7:0] b, output logic ack);
    logic s;
    int i;
    for (i = 7; i >= 0; i--)
      bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
endmodule

// ### smb_params.svh
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH
// register offsets in the default page and their reset values
`define SMB_SETTINGS_OFS 8'h8B
`define SMB_FLTCTL_OFS 8'h6D
`define SMB_SETTINGS_RST 8'h00
`define SMB_FLTCTL_RST 8'h00
// bus settings fields
`define SMB_PEC_BIT 7
`define SMB_SADDR_NONE 7'h00
// pin-selected address, upper five bits
`define SMB_PIN_ADDR_HI 5'h14
// command codes
`define SMB_CMD_BLKWR 8'hA5
`define SMB_CMD_BLKRD 8'hA6
`define SMB_CMD_REBOOT 8'hA7
`define SMB_CMD_FSTORE 8'hA8
`define SMB_CMD_FLASH_ON 8'hA9
`define SMB_CMD_FLASH_OFF 8'hAA
`define SMB_CMD_USER_ON 8'hAB
`define SMB_CMD_USER_OFF 8'hAC
// check byte generator and start value
`define SMB_CRC_POLY 8'h07
`define SMB_CRC_INIT 8'h00
// page limits and upper flash address bits
`define SMB_REG_LAST 8'h8D
`define SMB_USER_LO_LAST 8'h9F
`define SMB_USER_HI_FIRST 8'hB0
`define SMB_BASE_DEF 2'h0
`define SMB_BASE_FLASH 2'h2
`define SMB_BASE_USER 2'h3
// boot copy: flash source, register target, last index
`define SMB_BOOT_SRC 10'h230
`define SMB_BOOT_DST 8'h30
`define SMB_BOOT_LAST 7'h5C
// byte count reported first in a block read
`define SMB_BLOCK_COUNT 8'h08
`endif

// ### smb_pkg.sv
package smb_pkg;
  // serial engine states, gray along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD = 4'h2,
    ST_CMD_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hC
  } link_state_e;
  // address decoding page
  typedef enum logic [1:0] {
    PG_DEF = 2'h0,
    PG_FLASH = 2'h1,
    PG_USER = 2'h3
  } page_e;
endpackage

// ### smbus_slave_command_port.sv
// Summary of operation
// - pin ground, high, scl, sda give addresses 50h, 51h, 52h, 53h.
// - nonzero settings bits 6:0 override the pin-selected slave address.
// - a new programmed address applies right after its register write.
// - settings bit 7 enables packet checking; clear means no check byte.
// - with checking on, reads and writes carry one extra check byte.
// - check byte uses polynomial x^8 + x^2 + x + 1.
// - check covers address, command and data bytes, not acks or conditions.
// - send byte A7h starts a reboot equal to power-on reset.
// - boot copies flash 230h..28Ch into registers 30h..8Ch.
// - A8h triggers a fault store selected by fault log control.
// - A9h makes all addresses flash page addresses 200h..28Dh.
// - AAh returns decoding to the default page 000h..08Dh.
// - ABh from flash page selects user flash; ACh returns to flash page.
// - a send byte loads the register pointer for later transfers.
// - disallowed address or command byte is answered with nack.
// - A5h and A6h are acknowledged unless a reboot or flash write is busy.
// - stop before the pointer byte ack leaves the pointer unchanged.
// - eight command codes, A5h block write and A6h block read among them.
// - command byte is nacked during reboot, flash write or illegal address.
// - sda change while scl is high is taken as start or stop.
`timescale 1ns/1ps
`include "smb_params.svh"
module smbus_slave_command_port
  import smb_pkg::*;
(
  // clocks and reset
  input wire logic mclk,
  input wire logic link_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_select_pin,
  // flash port, link_clk domain
  input wire logic [7:0] flash_rdata,
  input wire logic flash_busy,
  output logic [9:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_we,
  output logic pec_fail,
  // device events, mclk domain
  output logic soft_reboot,
  output logic fault_store,
  output logic [7:0] fault_log_control
);
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, pin_s1, pin_s2;
  link_state_e st_r, st_nxt;
  page_e page_r, page_nxt;
  logic [3:0] bitc_r, bitc_nxt, nbyte_r, nbyte_nxt, rdi_r, rdi_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, cmd_r, cmd_nxt, crc_r, crc_nxt;
  logic [7:0] pend_r, pend_nxt, set_r, set_nxt, flt_r, flt_nxt, fsel_r, fsel_nxt;
  logic drv_r, drv_nxt, rw_r, rw_nxt, cpend_r, cpend_nxt, pv_r, pv_nxt, mack_r, mack_nxt;
  logic pst_r, pst_nxt, pfl_r, pfl_nxt, pri_r, pri_nxt, pf_r, pf_nxt, pen_r, pen_nxt;
  logic boot_r, boot_nxt, bwv_r, bwv_nxt, fst_r, fst_nxt, rbt_r, rbt_nxt;
  logic [6:0] bidx_r, bidx_nxt;
  logic [7:0] bwa_r, bwa_nxt, fwd_r, fwd_nxt, mem_wa, mem_wd, mem_rd, wr_a, wr_d, crc_upd;
  logic [9:0] fad_r, fad_nxt;
  logic fwe_r, fwe_nxt, mem_we, wr_go;
  logic start, stop, rise, fall, busy, cmd_ok, exec_ok;
  logic [7:0] byte_in, tx_byte, rd_data;
  logic [6:0] slv_addr;
  logic [1:0] sel;
  logic [3:0] rd_total;
  logic fs_s1, fs_s2, fs_s3, rb_s1, rb_s2, rb_s3, fs_pulse_r, rb_pulse_r, sda_o_r;
  logic [7:0] fsel_m_r;

  // page membership, used for pointer bytes and command checks
  function automatic logic addr_ok(input page_e pg, input logic [7:0] a);
    addr_ok = (pg == PG_USER) ? (a <= `SMB_USER_LO_LAST || a >= `SMB_USER_HI_FIRST)
                              : (a <= `SMB_REG_LAST);
  endfunction

  function automatic logic is_cmd(input logic [7:0] b);
    is_cmd = (b >= `SMB_CMD_BLKWR) && (b <= `SMB_CMD_USER_OFF);
  endfunction

  function automatic logic [1:0] page_base(input page_e pg);
    page_base = (pg == PG_DEF) ? `SMB_BASE_DEF : (pg == PG_FLASH) ? `SMB_BASE_FLASH
                                                                 : `SMB_BASE_USER;
  endfunction

  // pins pass two flops before any decode
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
      {pin_s1, pin_s2} <= 2'h0;
    end
    else
    begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
      {pin_s1, pin_s2} <= {addr_select_pin, pin_s1};
    end
  end

  // bus conditions from the synchronised lines
  assign start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop = scl_s2 && scl_d && !sda_d && sda_s2;
  assign rise = scl_s2 && !scl_d;
  assign fall = !scl_s2 && scl_d;
  assign byte_in = {sh_r[6:0], sda_s2};
  // pin level at start, first low and first high tells the four straps
  assign sel = pst_r ? (pfl_r ? 2'h1 : 2'h2) : (pri_r ? 2'h3 : 2'h0);
  assign slv_addr = (set_r[6:0] != `SMB_SADDR_NONE) ? set_r[6:0]
                                                    : {`SMB_PIN_ADDR_HI, sel};
  assign busy = boot_r || flash_busy;
  assign rd_data = (page_r == PG_DEF) ? mem_rd : flash_rdata;
  assign rd_total = (cmd_r == `SMB_CMD_BLKRD) ? 4'h9 : 4'h1;
  assign tx_byte = (cmd_r == `SMB_CMD_BLKRD && rdi_r == 4'h0) ? `SMB_BLOCK_COUNT
                 : (pen_r && rdi_r == rd_total) ? crc_r : rd_data;
  // command bytes: user page entry only from flash page, exit only from user page
  assign cmd_ok = !busy && (is_cmd(sh_r) ?
                  ((sh_r != `SMB_CMD_USER_ON || page_r == PG_FLASH) &&
                   (sh_r != `SMB_CMD_USER_OFF || page_r == PG_USER))
                  : addr_ok(page_r, sh_r));
  // with checking on the one trailing byte must bring the remainder to zero
  assign exec_ok = cpend_r && (pen_r ? (nbyte_r == 4'h1 && crc_r == 8'h00)
                                                   : (nbyte_r == 4'h0));

  pec_crc8 u_crc (
    .crc_in(crc_r),
    .data_in(byte_in),
    .crc_out(crc_upd)
  );

  reg_mem u_mem (
    .clk(link_clk),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(ptr_r),
    .rdata(mem_rd)
  );

  // serial engine, pointer, page and boot walk
  always_comb
  begin
    st_nxt = st_r; page_nxt = page_r; bitc_nxt = bitc_r; nbyte_nxt = nbyte_r;
    rdi_nxt = rdi_r; sh_nxt = sh_r; ptr_nxt = ptr_r; cmd_nxt = cmd_r; crc_nxt = crc_r;
    pend_nxt = pend_r; fsel_nxt = fsel_r; drv_nxt = drv_r; rw_nxt = rw_r;
    cpend_nxt = cpend_r; pv_nxt = pv_r; mack_nxt = mack_r; pst_nxt = pst_r;
    pfl_nxt = pfl_r; pri_nxt = pri_r; pf_nxt = 1'b0; boot_nxt = boot_r; pen_nxt = pen_r;
    bidx_nxt = bidx_r; fst_nxt = fst_r; rbt_nxt = rbt_r; fwd_nxt = fwd_r;
    fad_nxt = {page_base(page_r), ptr_r}; fwe_nxt = 1'b0;
    wr_go = 1'b0; wr_a = ptr_r; wr_d = sh_r;
    bwv_nxt = boot_r; bwa_nxt = `SMB_BOOT_DST + {1'b0, bidx_r};
    if (start)
    begin
      st_nxt = ST_ADDR; bitc_nxt = 4'h0; drv_nxt = 1'b0; rdi_nxt = 4'h0;
      pst_nxt = pin_s2;
      if (st_r == ST_IDLE)
      begin
        crc_nxt = `SMB_CRC_INIT;
        // checking mode frozen per frame: a frame that flips bit 7 keeps its own mode
        pen_nxt = set_r[`SMB_PEC_BIT];
        cmd_nxt = 8'h00; cpend_nxt = 1'b0; nbyte_nxt = 4'h0; pv_nxt = 1'b0;
      end
    end
    else if (stop)
    begin
      // the buffered byte was the check byte: never stored
      st_nxt = ST_IDLE; drv_nxt = 1'b0; cpend_nxt = 1'b0; pv_nxt = 1'b0;
      pf_nxt = pen_r && nbyte_r != 4'h0 && crc_r != 8'h00;
      if (exec_ok)
      begin
        case (cmd_r)
          `SMB_CMD_REBOOT:
          begin
            boot_nxt = 1'b1; bidx_nxt = 7'h00; page_nxt = PG_DEF; ptr_nxt = 8'h00;
            rbt_nxt = !rbt_r;
          end
          `SMB_CMD_FSTORE:
          begin
            fst_nxt = !fst_r; fsel_nxt = flt_r;
          end
          `SMB_CMD_FLASH_ON: page_nxt = PG_FLASH;
          `SMB_CMD_FLASH_OFF: page_nxt = PG_DEF;
          `SMB_CMD_USER_ON: page_nxt = PG_USER;
          `SMB_CMD_USER_OFF: page_nxt = PG_FLASH;
          default: page_nxt = page_r;
        endcase
      end
    end
    else if (rise)
    begin
      if (st_r == ST_RDATA_ACK)
      begin
        mack_nxt = !sda_s2;
      end
      else if (st_r != ST_IDLE && st_r != ST_ADDR_ACK && st_r != ST_CMD_ACK &&
               st_r != ST_WDATA_ACK && bitc_r < 4'h8)
      begin
        sh_nxt = byte_in; bitc_nxt = bitc_r + 4'h1;
        if (bitc_r == 4'h7) crc_nxt = crc_upd;
        if (st_r == ST_ADDR && bitc_r == 4'h0) pri_nxt = pin_s2;
      end
    end
    else if (fall)
    begin
      unique case (st_r)
        ST_IDLE: st_nxt = ST_IDLE;
        ST_ADDR:
          if (bitc_r == 4'h0) pfl_nxt = pin_s2;
          else if (bitc_r == 4'h8)
          begin
            // address change takes effect on the next header, no reboot
            drv_nxt = (sh_r[7:1] == slv_addr);
            rw_nxt = sh_r[0];
            st_nxt = (sh_r[7:1] == slv_addr) ? ST_ADDR_ACK : ST_IDLE;
          end
        ST_CMD:
          if (bitc_r == 4'h8)
          begin
            drv_nxt = cmd_ok; st_nxt = ST_CMD_ACK;
            if (cmd_ok)
            begin
              cmd_nxt = sh_r; nbyte_nxt = 4'h0;
              if (!is_cmd(sh_r)) ptr_nxt = sh_r;
              cpend_nxt = is_cmd(sh_r) && sh_r != `SMB_CMD_BLKWR &&
                          sh_r != `SMB_CMD_BLKRD;
            end
          end
        ST_WDATA:
          if (bitc_r == 4'h8)
          begin
            drv_nxt = 1'b1; st_nxt = ST_WDATA_ACK;
            if (nbyte_r != 4'hF) nbyte_nxt = nbyte_r + 4'h1;
            if (!(cmd_r == `SMB_CMD_BLKWR && nbyte_r == 4'h0) && !cpend_r)
            begin
              if (pen_r)
              begin
                // hold one byte back: the last one before stop is the check byte
                wr_go = pv_r; wr_d = pend_r; pend_nxt = sh_r; pv_nxt = 1'b1;
                if (pv_r) ptr_nxt = ptr_r + 8'h01;
              end
              else
              begin
                wr_go = 1'b1; ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        ST_RDATA:
          if (bitc_r == 4'h8)
          begin
            drv_nxt = 1'b0; bitc_nxt = 4'h0; st_nxt = ST_RDATA_ACK;
          end
          else drv_nxt = !sh_r[7];
        ST_ADDR_ACK, ST_RDATA_ACK:
          if ((st_r == ST_ADDR_ACK && rw_r) || (st_r == ST_RDATA_ACK && mack_r))
          begin
            sh_nxt = tx_byte; drv_nxt = !tx_byte[7]; bitc_nxt = 4'h0;
            st_nxt = ST_RDATA; rdi_nxt = rdi_r + 4'h1;
            if (tx_byte == rd_data && !(cmd_r == `SMB_CMD_BLKRD && rdi_r == 4'h0) &&
                !(pen_r && rdi_r == rd_total)) ptr_nxt = ptr_r + 8'h01;
          end
          else
          begin
            drv_nxt = 1'b0; bitc_nxt = 4'h0;
            st_nxt = (st_r == ST_ADDR_ACK) ? ST_CMD : ST_IDLE;
          end
        ST_CMD_ACK, ST_WDATA_ACK:
        begin
          drv_nxt = 1'b0; bitc_nxt = 4'h0;
          st_nxt = (st_r == ST_WDATA_ACK || drv_r) ? ST_WDATA : ST_IDLE;
        end
      endcase
    end
    // data writes: default page to registers, other pages to flash
    mem_we = wr_go && page_r == PG_DEF; mem_wa = wr_a; mem_wd = wr_d;
    if (wr_go && page_r != PG_DEF)
    begin
      fwe_nxt = 1'b1; fad_nxt = {page_base(page_r), wr_a}; fwd_nxt = wr_d;
    end
    // boot walk: address out this cycle, data stored the next
    if (boot_r)
    begin
      fad_nxt = `SMB_BOOT_SRC + {3'h0, bidx_r}; bidx_nxt = bidx_r + 7'h01;
      if (bidx_r == `SMB_BOOT_LAST) boot_nxt = 1'b0;
    end
    if (bwv_r)
    begin
      mem_we = 1'b1; mem_wa = bwa_r; mem_wd = flash_rdata;
    end
    set_nxt = (mem_we && mem_wa == `SMB_SETTINGS_OFS) ? mem_wd : set_r;
    flt_nxt = (mem_we && mem_wa == `SMB_FLTCTL_OFS) ? mem_wd : flt_r;
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE; page_r <= PG_DEF; bitc_r <= 4'h0; nbyte_r <= 4'h0; rdi_r <= 4'h0;
      sh_r <= 8'h00; ptr_r <= 8'h00; cmd_r <= 8'h00; crc_r <= `SMB_CRC_INIT;
      pend_r <= 8'h00; set_r <= `SMB_SETTINGS_RST; flt_r <= `SMB_FLTCTL_RST;
      fsel_r <= 8'h00; drv_r <= 1'b0; rw_r <= 1'b0; cpend_r <= 1'b0; pv_r <= 1'b0;
      mack_r <= 1'b0; pst_r <= 1'b0; pfl_r <= 1'b0; pri_r <= 1'b0; pf_r <= 1'b0;
      boot_r <= 1'b1; bidx_r <= 7'h00; bwv_r <= 1'b0; bwa_r <= 8'h00;
      fst_r <= 1'b0; rbt_r <= 1'b0; fwd_r <= 8'h00; fad_r <= 10'h000; fwe_r <= 1'b0;
      sda_o_r <= 1'b0; pen_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt; page_r <= page_nxt; bitc_r <= bitc_nxt; nbyte_r <= nbyte_nxt;
      rdi_r <= rdi_nxt; sh_r <= sh_nxt; ptr_r <= ptr_nxt; cmd_r <= cmd_nxt;
      crc_r <= crc_nxt; pend_r <= pend_nxt; set_r <= set_nxt; flt_r <= flt_nxt;
      fsel_r <= fsel_nxt; drv_r <= drv_nxt; rw_r <= rw_nxt; cpend_r <= cpend_nxt;
      pv_r <= pv_nxt; mack_r <= mack_nxt; pst_r <= pst_nxt; pfl_r <= pfl_nxt;
      pri_r <= pri_nxt; pf_r <= pf_nxt; boot_r <= boot_nxt; bidx_r <= bidx_nxt;
      bwv_r <= bwv_nxt; bwa_r <= bwa_nxt; fst_r <= fst_nxt; rbt_r <= rbt_nxt;
      fwd_r <= fwd_nxt; fad_r <= fad_nxt; fwe_r <= fwe_nxt; sda_o_r <= 1'b0; pen_r <= pen_nxt;
    end
  end

  // toggles into mclk; fsel_r is held stable until the next command
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {fs_s1, fs_s2, fs_s3, rb_s1, rb_s2, rb_s3} <= 6'h00;
      {fs_pulse_r, rb_pulse_r} <= 2'h0; fsel_m_r <= 8'h00;
    end
    else
    begin
      {fs_s1, fs_s2, fs_s3} <= {fst_r, fs_s1, fs_s2};
      {rb_s1, rb_s2, rb_s3} <= {rbt_r, rb_s1, rb_s2};
      fs_pulse_r <= fs_s2 ^ fs_s3;
      rb_pulse_r <= rb_s2 ^ rb_s3;
      if (fs_s2 ^ fs_s3) fsel_m_r <= fsel_r;
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe = drv_r;
  assign flash_addr = fad_r;
  assign flash_wdata = fwd_r;
  assign flash_we = fwe_r;
  assign pec_fail = pf_r;
  assign soft_reboot = rb_pulse_r;
  assign fault_store = fs_pulse_r;
  assign fault_log_control = fsel_m_r;

  property p_start;
    @(posedge link_clk) disable iff (!rst_n) start |=> st_r == ST_ADDR && bitc_r == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_crc0;
    @(posedge link_clk) disable iff (!rst_n) start && st_r == ST_IDLE |=> crc_r == 8'h00;
  endproperty
  a_crc0: assert property (p_crc0) else $error("check value not cleared");
  property p_pin_addr;
    @(posedge link_clk) disable iff (!rst_n)
      fall && st_r == ST_ADDR && bitc_r == 4'h8 && set_r[6:0] == 7'h00 &&
      sh_r[7:1] == {5'h14, sel} |=> drv_r ##1 drv_r;
  endproperty
  a_pin_addr: assert property (p_pin_addr) else $error("pin address not acked");
  property p_prog_addr;
    @(posedge link_clk) disable iff (!rst_n)
      fall && st_r == ST_ADDR && bitc_r == 4'h8 && set_r[6:0] != 7'h00 &&
      sh_r[7:1] != set_r[6:0] |=> !drv_r && st_r == ST_IDLE;
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("foreign address acked");
  property p_busy_nack;
    @(posedge link_clk) disable iff (!rst_n)
      fall && st_r == ST_CMD && bitc_r == 4'h8 && busy |=> !drv_r && $stable(ptr_r);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("busy command acked");
  property p_blk_ack;
    @(posedge link_clk) disable iff (!rst_n)
      fall && st_r == ST_CMD && bitc_r == 4'h8 && !busy &&
      (sh_r == 8'hA5 || sh_r == 8'hA6) |=> drv_r && st_r == ST_CMD_ACK;
  endproperty
  a_blk_ack: assert property (p_blk_ack) else $error("block command nacked");
  property p_bad_addr;
    @(posedge link_clk) disable iff (!rst_n)
      fall && st_r == ST_CMD && bitc_r == 4'h8 && page_r == PG_DEF && sh_r > 8'h8D &&
      !is_cmd(sh_r) |=> !drv_r;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("illegal address acked");
  property p_stop_ptr;
    @(posedge link_clk) disable iff (!rst_n) stop && st_r == ST_CMD |=> $stable(ptr_r);
  endproperty
  a_stop_ptr: assert property (p_stop_ptr) else $error("pointer moved on early stop");
  property p_reboot;
    @(posedge link_clk) disable iff (!rst_n)
      stop && exec_ok && cmd_r == 8'hA7 |=> boot_r && page_r == PG_DEF ##1 bwv_r;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot not started");
  property p_boot_dst;
    @(posedge link_clk) disable iff (!rst_n)
      bwv_r |-> mem_we && mem_wa >= 8'h30 && mem_wa <= 8'h8C;
  endproperty
  a_boot_dst: assert property (p_boot_dst) else $error("boot copy out of range");
  property p_flash_page;
    @(posedge link_clk) disable iff (!rst_n)
      stop && exec_ok && cmd_r == 8'hA9 |=> page_r == PG_FLASH ##1 flash_addr[9:8] == 2'h2;
  endproperty
  a_flash_page: assert property (p_flash_page) else $error("flash page not entered");
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk = 0, link_clk = 0, rst_n = 0, flash_busy = 0;
  logic [1:0] asel = 0;
  logic scl, sda_d, sda_o, sda_oe, addr_pin, fwe, pf, rb, fs, ack, bit_s;
  logic [9:0] faddr;
  logic [7:0] fwd, flc, v, c, d;
  // flash model: each byte holds its low address bits, settings byte kept clear
  wire [7:0] flash_rdata = (faddr == 10'h28B) ? 8'h00 : faddr[7:0];
  logic [17:0] wq[$];
  int fails = 0, n_compared = 0, n_rb = 0, n_fs = 0, n_pf = 0, i, k;
  // open drain wire with pull-up
  wire sda_w = sda_d & ~(sda_oe & ~sda_o);
  always #20 mclk = ~mclk;
  initial
  begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // strap follows ground, high, scl or sda
  assign addr_pin = asel == 0 ? 1'b0 : asel == 1 ? 1'b1 : asel == 2 ? scl : sda_w;
  smb_master m (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_d(sda_d));
  smbus_slave_command_port uut (.mclk(mclk), .link_clk(link_clk), .rst_n(rst_n),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_select_pin(addr_pin), .flash_rdata(flash_rdata), .flash_busy(flash_busy),
    .flash_addr(faddr), .flash_wdata(fwd), .flash_we(fwe), .pec_fail(pf),
    .soft_reboot(rb), .fault_store(fs), .fault_log_control(flc));
  // pulse counters and flash write log
  always @(posedge mclk)
  begin
    if (rb === 1'b1) n_rb++;
    if (fs === 1'b1) n_fs++;
  end
  always @(posedge link_clk)
  begin
    if (pf === 1'b1) n_pf++;
    if (fwe === 1'b1) wq.push_back({faddr, fwd});
  end
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // model of the check byte, msb first from zero
  function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] d);
    int j;
    a = a ^ d;
    for (j = 0; j < 8; j++)
      a = a[7] ? {a[6:0], 1'b0} ^ 8'h07 : {a[6:0], 1'b0};
    return a;
  endfunction
  // one write frame; nk is the byte expected to be refused, -1 none, -2 unchecked
  task automatic tx(input logic [6:0] a, input logic [7:0] d[$], input int nk);
    logic ack;
    int j;
    m.start();
    for (j = 0; j <= d.size(); j++)
    begin
      m.wbyte(j == 0 ? {a, 1'b0} : d[j-1], ack);
      if (nk != -2) chk(ack, j != nk);
      if (ack !== 1'b1) break;
    end
    m.stop();
  endtask
  // current address read of one byte, nacked by the master
  task automatic rx(output logic [7:0] q);
    logic a, s;
    int j;
    m.start();
    m.wbyte({7'h50, 1'b1}, a);
    chk(a, 1'b1);
    for (j = 7; j >= 0; j--)
    begin
      m.bitx(1'b1, s);
      q[j] = s;
    end
    m.bitx(1'b1, s);
    m.stop();
  endtask
  task automatic await(ref int cnt, input int want);
    int j;
    for (j = 0; j < 400 && cnt < want; j++)
      @(posedge mclk);
    chk(cnt, want);
  endtask
  initial
  begin
    #3ms;
    fails++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h980be530));
    v = 8'($urandom);
    c = 8'($urandom);
    repeat (12) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    repeat (120) @(posedge link_clk);
    for (i = 0; i < 4; i++)
    begin
      @(negedge mclk) asel = 2'(i);
      tx(7'(7'h50 + i), '{8'h00}, -1);
      tx(7'(7'h50 + (i + 1) % 4), '{8'h00}, 0);
    end
    @(negedge mclk) asel = 2'h0;
    $display("test strap done");
    tx(7'h50, '{8'h8E}, 1);
    tx(7'h50, '{8'hA5}, -1);
    tx(7'h50, '{8'hA6}, -1);
    tx(7'h50, '{8'hAB}, 1);
    @(negedge mclk) flash_busy = 1'b1;
    tx(7'h50, '{8'h00}, 1);
    @(negedge mclk) flash_busy = 1'b0;
    // programmed address kept clear of the reserved values
    tx(7'h50, '{8'h8B, 8'h33}, -1);
    tx(7'h50, '{8'h00}, 0);
    tx(7'h33, '{8'h8B, 8'h00}, -1);
    tx(7'h50, '{8'h00}, -1);
    $display("test command refusal and address done");
    tx(7'h50, '{8'h6D, v}, -1);
    tx(7'h50, '{8'hA8}, -1);
    await(n_fs, 1);
    chk(flc, v);
    // eight aligned single writes into flash page
    tx(7'h50, '{8'hA9}, -1);
    for (i = 0; i < 8; i++)
      tx(7'h50, '{8'(8 + i), 8'(v + i)}, -1);
    for (k = 0; k < 400 && wq.size() < 8; k++)
      @(posedge link_clk);
    chk(wq.size(), 8);
    for (i = 0; i < wq.size(); i++)
      chk(wq[i], {10'(10'h208 + i), 8'(v + i)});
    tx(7'h50, '{8'hAB}, -1);
    tx(7'h50, '{8'hAC}, -1);
    tx(7'h50, '{8'hAA}, -1);
    tx(7'h50, '{8'hAB}, 1);
    $display("test pages done");
    // pointer byte cut short by a stop: the pointer must stay at 40h
    tx(7'h50, '{8'h40}, -1);
    m.start();
    m.wbyte({7'h50, 1'b0}, ack);
    chk(ack, 1'b1);
    for (i = 0; i < 3; i++)
      m.bitx(1'b0, bit_s);
    m.stop();
    rx(d);
    chk(d, 8'h40);
    tx(7'h50, '{8'h20, c}, -1);
    tx(7'h50, '{8'h20}, -1);
    rx(d);
    chk(d, c);
    $display("test pointer and read done");
    tx(7'h50, '{8'h8B, 8'h80}, -1);
    c = crc8(crc8(crc8(8'h00, 8'hA0), 8'h6D), 8'h11);
    tx(7'h50, '{8'h6D, 8'h11, ~c}, -2);
    for (k = 0; k < 400 && n_pf < 1; k++)
      @(posedge link_clk);
    chk(n_pf, 1);
    c = crc8(crc8(8'h00, 8'hA0), 8'hA7);
    tx(7'h50, '{8'hA7, c}, -1);
    await(n_rb, 1);
    chk(n_pf, 1);
    repeat (120) @(posedge link_clk);
    // boot reloaded settings and 6Dh from flash
    tx(7'h50, '{8'hA8}, -1);
    await(n_fs, 2);
    chk(flc, 8'h6D);
    $display("test check byte and reboot done");
    report_and_stop();
  end
endmodule
